// [verilog/dim_regs.svh]
// register map, defaults, codes and timing for the digital input mapper
`ifndef DIM_REGS_SVH
`define DIM_REGS_SVH
`define DIM_OFS_SEL1 8'h00
`define DIM_OFS_SEL7 8'h18
`define DIM_OFS_CTRL 8'h1C
`define DIM_OFS_STAT 8'h20
`define DIM_OFS_INIT 8'h24
`define DIM_DEF_SEL1 8'h40
`define DIM_DEF_SEL2 8'h41
`define DIM_DEF_SEL3 8'h24
`define DIM_DEF_SEL4 8'h14
`define DIM_DEF_SEL5 8'h03
`define DIM_DEF_SEL6 8'h04
`define DIM_DEF_SEL7 8'h06
`define DIM_DEF3W_SEL5 8'h00
`define DIM_DEF3W_SEL6 8'h03
`define DIM_DEF3W_SEL7 8'h04
`define DIM_CODE_MAX 8'h9F
`define DIM_CODE_MIN12 8'h01
`define DIM_CODE_3WIRE 8'h00
`define DIM_CODE_LOCREM 8'h01
`define DIM_CODE_EXTSEL 8'h02
`define DIM_CODE_BB_NO 8'h08
`define DIM_CODE_BB_NC 8'h09
`define DIM_CODE_UNUSED 8'h0F
`define DIM_CODE_FAULTRST 8'h14
`define DIM_CODE_EF_HI 4'h2
`define DIM_CODE_FWD 8'h40
`define DIM_CODE_REV 8'h41
`define DIM_CTRL_PURUN 0
`define DIM_CTRL_RUNSW 1
`define DIM_CTRL_KEYLOC 2
`define DIM_INIT_NORMAL 32'h0000_0001
`define DIM_INIT_3WIRE 32'h0000_0003
`define DIM_RUN_MIN_NS 50000000
`define DIM_CLK_NS 100
`define DIM_RUN_CYC ((`DIM_RUN_MIN_NS + `DIM_CLK_NS - 1) / `DIM_CLK_NS)
`define DIM_FLASH_BIT 19
`endif

// [verilog/dim_pkg.sv]
// types for the digital input mapper
package dim_pkg;
  typedef enum logic [1:0] {DIM_IDLE = 2'b00, DIM_QUAL = 2'b01, DIM_RUN = 2'b11,
    DIM_LOCK = 2'b10} dim_state_t;
endpackage : dim_pkg

// [verilog/dim_sel_mem.sv]
// seven function-select words with registered read port
`timescale 1ns/1ps
`include "dim_regs.svh"
module dim_sel_mem (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic wrEn,
  input wire logic [2:0] wrIdx,
  input wire logic [7:0] wrData,
  input wire logic initReq,
  input wire logic init3w,
  input wire logic [2:0] rdIdx,
  output logic [7:0] rdData,
  output logic [55:0] allSel
);
  logic [7:0] sel [0:6];
  logic [7:0] next_sel [0:6];
  logic [7:0] next_rdData;
  always_comb
  begin
    for (int i = 0; i < 7; i++)
      next_sel[i] = sel[i];
    if (initReq)
    begin
      next_sel[0] = `DIM_DEF_SEL1;
      next_sel[1] = `DIM_DEF_SEL2;
      next_sel[2] = `DIM_DEF_SEL3;
      next_sel[3] = `DIM_DEF_SEL4;
      next_sel[4] = init3w ? `DIM_DEF3W_SEL5 : `DIM_DEF_SEL5;
      next_sel[5] = init3w ? `DIM_DEF3W_SEL6 : `DIM_DEF_SEL6;
      next_sel[6] = init3w ? `DIM_DEF3W_SEL7 : `DIM_DEF_SEL7;
    end
    else if (wrEn && wrIdx < 3'h7)
      next_sel[wrIdx] = wrData;
    next_rdData = (rdIdx < 3'h7) ? sel[rdIdx] : 8'h00;
  end
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      sel[0] <= `DIM_DEF_SEL1;
      sel[1] <= `DIM_DEF_SEL2;
      sel[2] <= `DIM_DEF_SEL3;
      sel[3] <= `DIM_DEF_SEL4;
      sel[4] <= `DIM_DEF_SEL5;
      sel[5] <= `DIM_DEF_SEL6;
      sel[6] <= `DIM_DEF_SEL7;
      rdData <= 8'h00;
    end
    else
    begin
      for (int i = 0; i < 7; i++)
        sel[i] <= next_sel[i];
      rdData <= next_rdData;
    end
  end
  assign allSel = {sel[6], sel[5], sel[4], sel[3], sel[2], sel[1], sel[0]};
endmodule : dim_sel_mem

// [verilog/dim_input_mapper.sv]
// multi-function digital input mapper with apb register access
`timescale 1ns/1ps
`include "dim_regs.svh"
module dim_input_mapper (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [7:1] in_term,
  input wire logic panelRun,
  input wire logic panelFwd,
  input wire logic local_remote_key,
  output logic runCmd,
  output logic revDir,
  output logic localMode,
  output logic localLed,
  output logic runLedFlash,
  output logic baseblock,
  output logic extFault,
  output logic faultReset,
  output logic extRefSel2
);
  ////////////////////////////////////////////////////////////////////////////
  // function code helpers
  function automatic logic anyCode(input logic [55:0] s, input logic [7:0] c);
    anyCode = 1'b0;
    for (int i = 0; i < 7; i++)
      if (s[i*8 +: 8] == c)
        anyCode = 1'b1;
  endfunction : anyCode
  function automatic logic anyClosed(input logic [55:0] s, input logic [7:1] t,
    input logic [7:0] c);
    anyClosed = 1'b0;
    for (int i = 0; i < 7; i++)
      if (s[i*8 +: 8] == c && t[i+1])
        anyClosed = 1'b1;
  endfunction : anyClosed
  function automatic logic codeOk(input logic [2:0] idx, input logic [7:0] c);
    codeOk = (c <= `DIM_CODE_MAX) && (idx > 3'h1 || c >= `DIM_CODE_MIN12);
  endfunction : codeOk
  ////////////////////////////////////////////////////////////////////////////
  // input synchronisers, first stage read only by second
  logic [7:1] syncA;
  logic [7:1] term;
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      syncA <= 7'h00;
      term <= 7'h00;
    end
    else
    begin
      syncA <= in_term;
      term <= syncA;
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  // apb slave and control registers
  logic [2:0] ctrl;
  logic [2:0] next_ctrl;
  logic [31:0] next_prdata;
  logic next_pready;
  logic next_pslverr;
  logic memWr;
  logic initReq;
  logic init3w;
  logic [7:0] memRd;
  logic [55:0] allSel;
  logic acc;
  logic selHit;
  logic [2:0] selIdx;
  assign acc = psel && penable && !pready;
  assign selHit = paddr <= `DIM_OFS_SEL7 && paddr[1:0] == 2'b00;
  assign selIdx = paddr[4:2];
  // on select-word reads pready waits one cycle so the select memory's registered read is valid
  logic waitRd;
  logic next_waitRd;
  always_comb
  begin
    next_ctrl = ctrl;
    next_prdata = prdata;
    next_pready = 1'b0;
    next_pslverr = 1'b0;
    next_waitRd = 1'b0;
    memWr = 1'b0;
    initReq = 1'b0;
    init3w = 1'b0;
    if (acc && !waitRd && !pwrite && selHit)
      next_waitRd = 1'b1;
    else if (acc)
    begin
      next_pready = 1'b1;
      if (pwrite)
      begin
        if (selHit)
        begin
          memWr = codeOk(selIdx, pwdata[7:0]);
          next_pslverr = !memWr;
        end
        else if (paddr == `DIM_OFS_CTRL)
          next_ctrl = pwdata[2:0];
        else if (paddr == `DIM_OFS_INIT)
        begin
          initReq = pwdata == `DIM_INIT_NORMAL || pwdata == `DIM_INIT_3WIRE;
          init3w = pwdata == `DIM_INIT_3WIRE;
          next_pslverr = !initReq;
        end
        else if (paddr != `DIM_OFS_STAT)
          next_pslverr = 1'b1;
      end
      else
      begin
        next_prdata = 32'h0000_0000;
        if (selHit)
          next_prdata = {24'h00_0000, memRd};
        else if (paddr == `DIM_OFS_CTRL)
          next_prdata = {29'h0000_0000, ctrl};
        else if (paddr == `DIM_OFS_STAT)
          next_prdata = {19'h0_0000, runLedFlash, localMode, revDir, runCmd,
            term, 1'b0, 1'b0};
        else if (paddr != `DIM_OFS_INIT)
          next_pslverr = 1'b1;
      end
    end
  end
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      ctrl <= 3'h0;
      prdata <= 32'h0000_0000;
      pready <= 1'b0;
      pslverr <= 1'b0;
      waitRd <= 1'b0;
    end
    else
    begin
      ctrl <= next_ctrl;
      prdata <= next_prdata;
      pready <= next_pready;
      pslverr <= next_pslverr;
      waitRd <= next_waitRd;
    end
  end
  dim_sel_mem u_mem (
    .clk(clk),
    .sys_rst(sys_rst),
    .wrEn(memWr),
    .wrIdx(selIdx),
    .wrData(pwdata[7:0]),
    .initReq(initReq),
    .init3w(init3w),
    .rdIdx(selIdx),
    .rdData(memRd),
    .allSel(allSel)
  );
  ////////////////////////////////////////////////////////////////////////////
  // function decode; code F matches nothing so it drives no function
  logic threeWire;
  logic lrAssigned;
  logic lrClosed;
  logic dirIn;
  logic want2Fwd;
  logic want2Rev;
  logic [2:0] efHit;
  assign threeWire = anyCode(allSel, `DIM_CODE_3WIRE);
  assign lrAssigned = anyCode(allSel, `DIM_CODE_LOCREM);
  assign lrClosed = anyClosed(allSel, term, `DIM_CODE_LOCREM);
  assign dirIn = anyClosed(allSel, term, `DIM_CODE_3WIRE);
  assign want2Fwd = anyClosed(allSel, term, `DIM_CODE_FWD);
  assign want2Rev = anyClosed(allSel, term, `DIM_CODE_REV);
  always_comb
  begin
    efHit = 3'h0;
    for (int i = 0; i < 7; i++)
    begin
      if (allSel[i*8+4 +: 4] == `DIM_CODE_EF_HI && term[i+1])
        efHit[0] = 1'b1;
      if ((allSel[i*8 +: 8] == `DIM_CODE_BB_NO && term[i+1]) ||
          (allSel[i*8 +: 8] == `DIM_CODE_BB_NC && !term[i+1]))
        efHit[1] = 1'b1;
      if (allSel[i*8 +: 8] == `DIM_CODE_FAULTRST && term[i+1])
        efHit[2] = 1'b1;
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  // local/remote and panel key
  logic keyD;
  logic next_localMode;
  logic wantLocal;
  assign wantLocal = lrAssigned ? lrClosed : ctrl[`DIM_CTRL_KEYLOC];
  always_comb
  begin
    next_localMode = localMode;
    if (!lrAssigned && local_remote_key && !keyD && !runCmd)
      next_localMode = !localMode;
    else if (wantLocal != localMode && (!runCmd || ctrl[`DIM_CTRL_RUNSW]))
      next_localMode = wantLocal;
  end
  ////////////////////////////////////////////////////////////////////////////
  // run sequencing
  dim_pkg::dim_state_t st;
  dim_pkg::dim_state_t next_st;
  logic [19:0] qualCnt;
  logic [19:0] next_qualCnt;
  logic [19:0] flashCnt;
  logic [2:0] warm;
  logic reqRun;
  logic next_revDir;
  always_comb
  begin
    next_st = st;
    next_qualCnt = 20'h0_0000;
    next_revDir = revDir;
    reqRun = 1'b0;
    if (localMode)
    begin
      reqRun = panelRun;
      next_revDir = !panelFwd;
    end
    else if (threeWire)
    begin
      reqRun = term[1];
      next_revDir = dirIn;
    end
    else
    begin
      reqRun = want2Fwd ^ want2Rev;
      if (reqRun)
        next_revDir = want2Rev;
    end
    case (st)
      dim_pkg::DIM_IDLE:
      begin
        if (!warm[2] && reqRun && !ctrl[`DIM_CTRL_PURUN])
          next_st = dim_pkg::DIM_LOCK;
        else if (!warm[2] && reqRun)
          next_st = dim_pkg::DIM_RUN;
        else if (!localMode && threeWire && term[1] && term[2])
          next_st = dim_pkg::DIM_QUAL;
        else if (reqRun && !(!localMode && threeWire))
          next_st = dim_pkg::DIM_RUN;
      end
      dim_pkg::DIM_QUAL:
      begin
        next_qualCnt = qualCnt + 20'h0_0001;
        if (!term[1] || !term[2])
          next_st = dim_pkg::DIM_IDLE;
        else if (qualCnt >= 20'(`DIM_RUN_CYC))
          next_st = dim_pkg::DIM_RUN;
      end
      dim_pkg::DIM_RUN:
      begin
        if (!localMode && threeWire)
        begin
          if (!term[2])
            next_st = dim_pkg::DIM_IDLE;
        end
        else if (!reqRun)
          next_st = dim_pkg::DIM_IDLE;
      end
      dim_pkg::DIM_LOCK:
        if (!reqRun)
          next_st = dim_pkg::DIM_IDLE;
      default:
        next_st = dim_pkg::DIM_IDLE;
    endcase
  end
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      st <= dim_pkg::DIM_IDLE;
      qualCnt <= 20'h0_0000;
      flashCnt <= 20'h0_0000;
      warm <= 3'h0;
      keyD <= 1'b0;
      localMode <= 1'b0;
      revDir <= 1'b0;
      runCmd <= 1'b0;
      localLed <= 1'b0;
      runLedFlash <= 1'b0;
      baseblock <= 1'b0;
      extFault <= 1'b0;
      faultReset <= 1'b0;
      extRefSel2 <= 1'b0;
    end
    else
    begin
      st <= next_st;
      qualCnt <= next_qualCnt;
      flashCnt <= flashCnt + 20'h0_0001;
      warm <= initReq ? 3'h0 : {warm[1:0], 1'b1}; // window closes once sync is full
      keyD <= local_remote_key;
      localMode <= next_localMode;
      revDir <= next_revDir;
      runCmd <= next_st == dim_pkg::DIM_RUN;
      localLed <= next_localMode;
      runLedFlash <= next_st == dim_pkg::DIM_LOCK && !flashCnt[`DIM_FLASH_BIT];
      baseblock <= efHit[1];
      extFault <= efHit[0];
      faultReset <= efHit[2];
      extRefSel2 <= anyClosed(allSel, term, `DIM_CODE_EXTSEL);
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  // checks
  property p_stop3w;
    @(posedge clk) disable iff (sys_rst)
      (st == dim_pkg::DIM_RUN && !localMode && threeWire && !term[2]) |=> !runCmd;
  endproperty
  a_stop3w: assert property (p_stop3w) else $error("3-wire stop ignored");
  property p_qual;
    @(posedge clk) disable iff (sys_rst)
      (st == dim_pkg::DIM_IDLE && next_st == dim_pkg::DIM_QUAL) |=> !runCmd [*8];
  endproperty
  a_qual: assert property (p_qual) else $error("run before qualification");
  property p_lock;
    @(posedge clk) disable iff (sys_rst)
      st == dim_pkg::DIM_LOCK |-> !runCmd;
  endproperty
  a_lock: assert property (p_lock) else $error("locked run started");
  property p_led;
    @(posedge clk) disable iff (sys_rst) localLed == localMode;
  endproperty
  a_led: assert property (p_led) else $error("local led mismatch");
  property p_lrlocal;
    @(posedge clk) disable iff (sys_rst)
      (lrAssigned && lrClosed && !runCmd) ##1 (lrAssigned && lrClosed) |-> localMode;
  endproperty
  a_lrlocal: assert property (p_lrlocal) else $error("local not taken");
  property p_hold;
    @(posedge clk) disable iff (sys_rst)
      (runCmd && !ctrl[`DIM_CTRL_RUNSW]) |=> $stable(localMode);
  endproperty
  a_hold: assert property (p_hold) else $error("source changed in run");
  property p_dir;
    @(posedge clk) disable iff (sys_rst)
      (!localMode && threeWire) |=> revDir == $past(dirIn);
  endproperty
  a_dir: assert property (p_dir) else $error("3-wire direction wrong");
  property p_sync;
    @(posedge clk) disable iff (sys_rst) !$past(sys_rst, 2) |-> term == $past(in_term, 2);
  endproperty
  a_sync: assert property (p_sync) else $error("sync depth wrong");
endmodule : dim_input_mapper

// [bench/dim_contacts.sv]
// behavioural model of the switches wired to the seven input terminals
`timescale 1ns/1ps
module dim_contacts (
  input wire logic clk,
  input wire logic [7:1] want,
  output logic [7:1] in_term
);
  // contacts close or open as commanded and stay put until told otherwise,
  // so a run closure lasts exactly as long as the bench asks
  // unused terminals are configured by the bench, not here
  always_ff @(posedge clk)
  begin
    in_term <= want;
  end
endmodule : dim_contacts

// [bench/tb.sv]
// self-checking testbench for the digital input mapper
`timescale 1ns/1ps
`include "dim_regs.svh"
module tb;
  logic clk;
  logic sys_rst;
  logic psel;
  logic penable;
  logic pwrite;
  logic [7:0] paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic [7:1] want;
  logic [7:1] inTerm;
  logic keyIn;
  logic panelRun;
  logic panelFwd;
  logic runCmd, revDir, localMode, localLed, runLedFlash;
  logic baseblock, extFault, faultReset, extRefSel2;
  logic [31:0] q;
  logic e;
  int failures = 0;
  int checked = 0;
  localparam logic [7:0] DEFS [7] = '{`DIM_DEF_SEL1, `DIM_DEF_SEL2, `DIM_DEF_SEL3,
    `DIM_DEF_SEL4, `DIM_DEF_SEL5, `DIM_DEF_SEL6, `DIM_DEF_SEL7};
  dim_contacts cont_u (.clk(clk), .want(want), .in_term(inTerm));
  dim_input_mapper dut_u (.clk(clk), .sys_rst(sys_rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .in_term(inTerm), .panelRun(panelRun), .panelFwd(panelFwd),
    .local_remote_key(keyIn), .runCmd(runCmd), .revDir(revDir), .localMode(localMode),
    .localLed(localLed), .runLedFlash(runLedFlash), .baseblock(baseblock),
    .extFault(extFault), .faultReset(faultReset), .extRefSel2(extRefSel2));
  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    checked++;
    if (got !== exp)
    begin
      failures++;
      $display("[ERR] %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask : chk
  // one apb transfer; a dead slave is caught by the watchdog
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    // look mid-cycle at what the next rising edge will sample
    do
    begin
      @(negedge clk);
      n++;
    end
    while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    chk(n, (!wr && a <= `DIM_OFS_SEL7) ? 32'h0000_0003 : 32'h0000_0002, "answer latency");
    @(posedge clk);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic ee);
    apb(1'b1, a, d);
    chk(e, ee, "write error flag");
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [31:0] x, input logic ee);
    apb(1'b0, a, 32'h0000_0000);
    chk(e, ee, "read error flag");
    chk(q, x, "read data");
  endtask : rd
  // sync takes two cycles and outputs one more; six leaves margin
  task automatic settle;
    repeat (6) @(posedge clk);
    #1;
  endtask : settle
  task automatic finish_test;
    $display("checks %0d failures %0d", checked, failures);
    if (failures == 0 && checked > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : finish_test
  ////////////////////////////////////////////////////////////////////////////////
  task automatic t_powerup;
    settle();
    chk(runCmd, 1'b0, "run at power up");
    chk(runLedFlash, 1'b1, "protection indicator");
    want <= 7'h00;
    settle();
    chk(runLedFlash, 1'b0, "indicator off once released");
    $display("done powerup");
  endtask : t_powerup
  task automatic t_defaults;
    for (int i = 0; i < 7; i++)
      rd(8'(4 * i), {24'h000000, DEFS[i]}, 1'b0);
    $display("done defaults");
  endtask : t_defaults
  task automatic t_refuse;
    wr(8'h00, 32'h0000_0000, 1'b1);
    wr(8'h08, 32'h0000_00A0, 1'b1);
    rd(8'h00, 32'h0000_0040, 1'b0);
    rd(8'h08, 32'h0000_0024, 1'b0);
    wr(8'h08, 32'h0000_0000, 1'b0);
    rd(8'h08, 32'h0000_0000, 1'b0);
    wr(8'h18, 32'h0000_009F, 1'b0);
    rd(8'h18, 32'h0000_009F, 1'b0);
    wr(8'h08, 32'h0000_0024, 1'b0);
    wr(8'h18, 32'h0000_0006, 1'b0);
    rd(8'h30, 32'h0000_0000, 1'b1);
    $display("done refuse");
  endtask : t_refuse
  task automatic t_two_wire;
    want <= 7'h01;
    settle();
    chk({runCmd, revDir}, 2'b10, "forward run");
    want <= 7'h02;
    settle();
    chk({runCmd, revDir}, 2'b11, "reverse run");
    want <= 7'h00;
    settle();
    chk(runCmd, 1'b0, "stopped");
    $display("done two wire");
  endtask : t_two_wire
  task automatic t_codes;
    want <= 7'h04;
    settle();
    chk(extFault, 1'b1, "external fault");
    want <= 7'h00;
    wr(8'h0C, 32'h0000_0008, 1'b0);
    settle();
    chk(baseblock, 1'b0, "open contact no block");
    want <= 7'h08;
    settle();
    chk(baseblock, 1'b1, "closed contact blocks");
    want <= 7'h00;
    wr(8'h0C, 32'h0000_0009, 1'b0);
    settle();
    chk(baseblock, 1'b1, "open break contact blocks");
    wr(8'h0C, 32'h0000_0002, 1'b0);
    want <= 7'h08;
    settle();
    chk({extRefSel2, baseblock}, 2'b10, "second reference source");
    wr(8'h0C, 32'h0000_0014, 1'b0);
    settle();
    chk({faultReset, extRefSel2}, 2'b10, "fault reset input");
    want <= 7'h00;
    $display("done codes");
  endtask : t_codes
  task automatic t_locrem;
    wr(8'h08, 32'h0000_0001, 1'b0);
    want <= 7'h04;
    settle();
    chk(localMode, 1'b1, "local when closed");
    chk(localLed, 1'b1, "local indicator");
    @(posedge clk);
    keyIn <= 1'b1;
    settle();
    @(posedge clk);
    keyIn <= 1'b0;
    settle();
    chk(localMode, 1'b1, "key ignored");
    @(posedge clk);
    panelRun <= 1'b1;
    panelFwd <= 1'b0;
    settle();
    chk({runCmd, revDir}, 2'b11, "panel run in local");
    want <= 7'h00;
    settle();
    chk(localMode, 1'b1, "source held while running");
    @(posedge clk);
    panelRun <= 1'b0;
    panelFwd <= 1'b1;
    settle();
    chk({localMode, localLed}, 2'b00, "remote when open");
    wr(8'h08, 32'h0000_0024, 1'b0);
    $display("done local remote");
  endtask : t_locrem
  task automatic t_through;
    wr(8'h14, 32'h0000_000F, 1'b0);
    want <= 7'h20;
    settle();
    apb(1'b0, 8'h20, 32'h0000_0000);
    chk(q[7], 1'b1, "contact readable");
    chk({runCmd, baseblock, extFault, faultReset, localMode}, 5'h00, "no function");
    want <= 7'h00;
    $display("done through");
  endtask : t_through
  task automatic t_three_wire;
    wr(8'h24, `DIM_INIT_3WIRE, 1'b0);
    rd(8'h10, 32'h0000_0000, 1'b0);
    rd(8'h14, 32'h0000_0003, 1'b0);
    rd(8'h18, 32'h0000_0004, 1'b0);
    // full 50 ms qualification is too long here; a short closure must not start
    want <= 7'h03;
    repeat (2000) @(posedge clk);
    #1;
    chk(runCmd, 1'b0, "short closure");
    want <= 7'h00;
    settle();
    wr(`DIM_OFS_INIT, `DIM_INIT_NORMAL, 1'b0);
    wr(`DIM_OFS_CTRL, 32'h0000_0001, 1'b0);
    want <= 7'h13;
    settle();
    chk(runCmd, 1'b0, "forward and reverse together");
    wr(`DIM_OFS_INIT, `DIM_INIT_3WIRE, 1'b0);
    settle();
    chk({runCmd, revDir}, 2'b11, "run accepted at init");
    want <= 7'h11;
    settle();
    chk(runCmd, 1'b0, "stop input opened");
    want <= 7'h00;
    settle();
    $display("done three wire");
  endtask : t_three_wire
  ////////////////////////////////////////////////////////////////////////////////
  initial
  begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  initial
  begin
    #(100 * 20000);
    failures++;
    $display("[ERR] %0t watchdog expired", $time);
    finish_test();
  end
  initial
  begin
    sys_rst = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0000_0000;
    keyIn = 1'b0;
    panelRun = 1'b0;
    panelFwd = 1'b1;
    want = 7'h01;
    repeat (20) @(posedge clk);
    sys_rst <= 1'b0;
    t_powerup();
    t_defaults();
    t_refuse();
    t_two_wire();
    t_codes();
    t_locrem();
    t_through();
    t_three_wire();
    finish_test();
  end
endmodule : tb
